// file: design/pan_autoneg.sv
// Auto-negotiation control with its management registers
// Behaviour
// - Straps sampled after reset into advertised bits
// - Strap codes map to four ability sets
// - Advertisement writes override the strap setup after its load cycle
// - Bursts carry the advertised abilities
// - Fixed priority picks the common mode
// - Control register enables, disables, restarts negotiation
// - Forced mode uses speed and duplex bits
// - Speed and duplex bits ignored while negotiating
// - Link status register reports operating speed, resolved or forced
// - Ability bits fixed, four-pair ability zero
// - Status shows complete, fault, link, preamble
// - Straps set the default advertisement (all only with both straps high), writes suppress abilities
// - Partner register captures pages received in ability, ack and check states
// - Parallel detection loads fixed partner words
// - Expansion register reports page and detect status
// - Restart bit restarts negotiation at any time
// - Restart holds link quiet for break interval
// - Lost link resumes negotiation automatically
`timescale 1ns/100ps
`include "pan_defs.svh"
module pan_autoneg #(
	parameter int unsigned BREAK_CYCLES = `PAN_BREAK_MS * `PAN_CLK_KHZ,
	parameter int unsigned BURST_CYCLES = `PAN_BURST_MS * `PAN_CLK_KHZ
) (
	input logic clock,
	input logic rstn,
	input logic adv_strap_hi,
	input logic adv_strap_lo,
	input logic [4:0] mgmt_addr,
	input logic mgmt_write,
	input logic mgmt_read,
	input logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	input logic rx_page_valid,
	input logic [15:0] rx_page_word,
	input logic link_100_good,
	input logic link_10_good,
	output logic flp_send,
	output logic [15:0] flp_word,
	output logic tx_hold,
	output logic link_up,
	output logic op_speed_100,
	output logic op_full_duplex,
	output logic neg_complete
);
	localparam logic [`PAN_TMR_W-1:0] BREAK_LD = `PAN_TMR_W'(BREAK_CYCLES - 1);
	localparam logic [`PAN_TMR_W-1:0] BURST_LD = `PAN_TMR_W'(BURST_CYCLES - 1);

	pan_pkg::pan_state_type state;
	pan_pkg::pan_state_type next_state;
	logic [`PAN_TMR_W-1:0] timer;
	logic timer_done;
	logic ctl_anen;
	logic ctl_speed;
	logic ctl_duplex;
	logic [3:0] adv;
	logic [15:0] partner;
	logic lp_an;
	logic page_rcvd;
	logic pdf;
	logic [3:0] strap_adv;
	logic strap_load;
	logic wr_ctl;
	logic wr_adv;
	logic rd_exp;
	logic link_ok;
	logic forced_link;
	logic pd_one;
	logic pd_both;
	logic page_state;
	logic burst_state;
	logic [15:0] ctl_word;
	logic [15:0] stat_word;
	logic [15:0] exp_word;
	logic [15:0] ls_word;
	logic [15:0] rd_mux;

	pan_res_if res ();

	function automatic logic pan_mapped(input logic [4:0] a);
		return a == `PAN_ADDR_MODE_CTRL || a == `PAN_ADDR_MODE_STAT ||
			a == `PAN_ADDR_ADVERT || a == `PAN_ADDR_PARTNER ||
			a == `PAN_ADDR_EXPANSION || a == `PAN_ADDR_LINK_STAT;
	endfunction

	function automatic logic [15:0] pan_base_word(input logic [3:0] abil, input logic ack);
		logic [15:0] w;
		w = `PAN_SEL_FIELD;
		w[`PAN_ADV_HI:`PAN_ADV_LO] = abil;
		w[`PAN_ACK_BIT] = ack;
		return w;
	endfunction

	pan_strap_sample u_strap (
		.clock(clock),
		.rstn(rstn),
		.adv_strap_hi(adv_strap_hi),
		.adv_strap_lo(adv_strap_lo),
		.strap_adv(strap_adv),
		.strap_load(strap_load)
	);

	pan_resolve u_resolve (
		.clock(clock),
		.rstn(rstn),
		.res(res.resolver)
	);

	assign res.local_adv = adv;
	assign res.partner_adv = partner[`PAN_ADV_HI:`PAN_ADV_LO];

	assign wr_ctl = mgmt_write && mgmt_addr == `PAN_ADDR_MODE_CTRL;
	assign wr_adv = mgmt_write && mgmt_addr == `PAN_ADDR_ADVERT;
	assign rd_exp = mgmt_read && mgmt_addr == `PAN_ADDR_EXPANSION;
	assign timer_done = timer == '0;
	assign pd_one = link_100_good ^ link_10_good;
	assign pd_both = link_100_good && link_10_good;
	assign link_ok = res.speed_100 ? link_100_good : link_10_good;
	assign forced_link = ctl_speed ? link_100_good : link_10_good;
	assign page_state = state inside {pan_pkg::ST_ABILITY, pan_pkg::ST_ACK, pan_pkg::ST_CHECK};
	assign burst_state = state inside {pan_pkg::ST_ABILITY, pan_pkg::ST_ACK};

	// Link pulses and data are held off only during the break interval
	assign tx_hold = state == pan_pkg::ST_BREAK;
	assign flp_send = burst_state && timer_done;

	always_comb begin
		next_state = state;
		unique case (state)
			pan_pkg::ST_OFF: begin
				if (ctl_anen)
					next_state = pan_pkg::ST_ABILITY;
			end
			pan_pkg::ST_BREAK: begin
				if (timer_done)
					next_state = pan_pkg::ST_ABILITY;
			end
			pan_pkg::ST_ABILITY: begin
				if (rx_page_valid)
					next_state = pan_pkg::ST_ACK;
				else if (pd_one)
					next_state = pan_pkg::ST_CHECK;
			end
			pan_pkg::ST_ACK: begin
				if (rx_page_valid && rx_page_word[`PAN_ACK_BIT])
					next_state = pan_pkg::ST_CHECK;
			end
			pan_pkg::ST_CHECK: begin
				if (!res.valid)
					next_state = pan_pkg::ST_ABILITY;
				else if (link_ok)
					next_state = pan_pkg::ST_GOOD;
			end
			pan_pkg::ST_GOOD: begin
				if (!link_ok)
					next_state = pan_pkg::ST_ABILITY;
			end
		endcase
		if (wr_ctl) begin
			if (!mgmt_wdata[`PAN_CTL_ANEN])
				next_state = pan_pkg::ST_OFF;
			else if (mgmt_wdata[`PAN_CTL_RESTART] || !ctl_anen)
				next_state = pan_pkg::ST_BREAK;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			state <= pan_pkg::ST_ABILITY;
		else
			state <= next_state;
	end

	// One timer serves the break interval and the burst spacing
	always_ff @(posedge clock) begin
		if (!rstn)
			timer <= '0;
		else if (next_state != state || (wr_ctl && next_state == pan_pkg::ST_BREAK))
			timer <= (next_state == pan_pkg::ST_BREAK) ? BREAK_LD : BURST_LD;
		else if (timer_done)
			timer <= BURST_LD;
		else
			timer <= timer - `PAN_TMR_W'(1);
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			flp_word <= pan_base_word(`PAN_ADV_ALL, 1'h0);
		else
			flp_word <= pan_base_word(adv, state == pan_pkg::ST_ACK);
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ctl_anen <= `PAN_CTL_RST_ANEN;
			ctl_speed <= `PAN_CTL_RST_SPEED;
			ctl_duplex <= `PAN_CTL_RST_DUPLEX;
		end else if (wr_ctl) begin
			ctl_anen <= mgmt_wdata[`PAN_CTL_ANEN];
			ctl_speed <= mgmt_wdata[`PAN_CTL_SPEED];
			ctl_duplex <= mgmt_wdata[`PAN_CTL_DUPLEX];
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			adv <= `PAN_ADV_ALL;
		else if (strap_load)
			adv <= strap_adv;
		else if (wr_adv)
			adv <= mgmt_wdata[`PAN_ADV_HI:`PAN_ADV_LO];
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			partner <= 16'h0000;
			lp_an <= 1'h0;
		end else if (next_state == pan_pkg::ST_BREAK || next_state == pan_pkg::ST_OFF) begin
			partner <= 16'h0000;
			lp_an <= 1'h0;
		end else if (page_state && rx_page_valid) begin
			partner <= rx_page_word;
			lp_an <= 1'h1;
		end else if (state == pan_pkg::ST_ABILITY && pd_one) begin
			partner <= link_100_good ? `PAN_PD_100 : `PAN_PD_10;
		end
	end

	// Hardware set wins over the clear by reading the expansion register
	always_ff @(posedge clock) begin
		if (!rstn)
			page_rcvd <= 1'h0;
		else if (page_state && rx_page_valid)
			page_rcvd <= 1'h1;
		else if (rd_exp)
			page_rcvd <= 1'h0;
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			pdf <= 1'h0;
		else if (state == pan_pkg::ST_ABILITY && pd_both && !rx_page_valid)
			pdf <= 1'h1;
		else if (rd_exp)
			pdf <= 1'h0;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			op_speed_100 <= `PAN_CTL_RST_SPEED;
			op_full_duplex <= `PAN_CTL_RST_DUPLEX;
		end else if (state == pan_pkg::ST_OFF) begin
			op_speed_100 <= ctl_speed;
			op_full_duplex <= ctl_duplex;
		end else begin
			op_speed_100 <= res.speed_100;
			op_full_duplex <= res.full_duplex;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			link_up <= 1'h0;
			neg_complete <= 1'h0;
		end else begin
			link_up <= (state == pan_pkg::ST_OFF) ? forced_link : state == pan_pkg::ST_GOOD;
			neg_complete <= state == pan_pkg::ST_GOOD;
		end
	end

	always_comb begin
		ctl_word = 16'h0000;
		ctl_word[`PAN_CTL_SPEED] = ctl_speed;
		ctl_word[`PAN_CTL_ANEN] = ctl_anen;
		ctl_word[`PAN_CTL_DUPLEX] = ctl_duplex;
		stat_word = `PAN_STAT_FIXED;
		stat_word[`PAN_STAT_CMPL] = neg_complete;
		stat_word[`PAN_STAT_RFLT] = partner[`PAN_RF_BIT];
		stat_word[`PAN_STAT_LINK] = link_up;
		exp_word = 16'h0000;
		exp_word[`PAN_EXP_PDF] = pdf;
		exp_word[`PAN_EXP_LPNP] = lp_an && partner[`PAN_NP_BIT];
		exp_word[`PAN_EXP_NP] = `PAN_LOCAL_NP;
		exp_word[`PAN_EXP_PAGE] = page_rcvd;
		exp_word[`PAN_EXP_LPAN] = lp_an;
		ls_word = 16'h0000;
		ls_word[`PAN_LS_LINK] = link_up;
		ls_word[`PAN_LS_SPEED10] = !op_speed_100;
		ls_word[`PAN_LS_DUPLEX] = op_full_duplex;
		ls_word[`PAN_LS_CMPL] = neg_complete;
	end

	always_comb begin
		case (mgmt_addr)
			`PAN_ADDR_MODE_CTRL: rd_mux = ctl_word;
			`PAN_ADDR_MODE_STAT: rd_mux = stat_word;
			`PAN_ADDR_ADVERT: rd_mux = pan_base_word(adv, 1'h0);
			`PAN_ADDR_PARTNER: rd_mux = partner;
			`PAN_ADDR_EXPANSION: rd_mux = exp_word;
			`PAN_ADDR_LINK_STAT: rd_mux = ls_word;
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			mgmt_rdata <= 16'h0000;
		else if (mgmt_read)
			mgmt_rdata <= pan_mapped(mgmt_addr) ? rd_mux : 16'h0000;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	sequence s_restart_wr;
		wr_ctl && mgmt_wdata[`PAN_CTL_ANEN] && mgmt_wdata[`PAN_CTL_RESTART];
	endsequence
	sequence s_quiet;
		(state == pan_pkg::ST_BREAK && tx_hold && !flp_send)[*2];
	endsequence

	strap_load_a: assert property (strap_load |=> adv == $past(strap_adv))
		else $error("strap value not loaded into advertisement");
	restart_break_a: assert property (s_restart_wr |=> s_quiet)
		else $error("restart did not enter quiet break");
	break_quiet_a: assert property (state == pan_pkg::ST_BREAK |-> tx_hold && !flp_send)
		else $error("pulses sent during break interval");
	burst_word_a: assert property (flp_send |-> flp_word[`PAN_ADV_HI:`PAN_ADV_LO] == $past(adv))
		else $error("burst word does not carry advertisement");
	forced_mode_a: assert property (state == pan_pkg::ST_OFF |=>
		op_speed_100 == $past(ctl_speed) && op_full_duplex == $past(ctl_duplex))
		else $error("forced mode not taken from control bits");
	neg_ignore_a: assert property (state inside {pan_pkg::ST_CHECK, pan_pkg::ST_GOOD} |=>
		op_speed_100 == $past(res.speed_100))
		else $error("speed bit used while negotiating");
	link_loss_a: assert property (state == pan_pkg::ST_GOOD && !link_ok && !wr_ctl |=>
		state == pan_pkg::ST_ABILITY ##1 !neg_complete)
		else $error("lost link did not resume negotiation");
	pd_load_a: assert property (state == pan_pkg::ST_ABILITY && !rx_page_valid &&
		link_100_good && !link_10_good && !wr_ctl |=> partner == `PAN_PD_100)
		else $error("parallel detect word not loaded");
	page_cap_a: assert property (page_state && rx_page_valid && !wr_ctl |=>
		partner == $past(rx_page_word))
		else $error("received page not captured");
	fixed_abil_a: assert property (mgmt_read && mgmt_addr == `PAN_ADDR_MODE_STAT |=>
		mgmt_rdata[15:11] == 5'h0f && mgmt_rdata[3] && mgmt_rdata[0])
		else $error("fixed ability bits wrong");
	link_speed_a: assert property (mgmt_read && mgmt_addr == `PAN_ADDR_LINK_STAT |=>
		mgmt_rdata[`PAN_LS_SPEED10] == !$past(op_speed_100))
		else $error("link status speed wrong");
	unmapped_zero_a: assert property (mgmt_read && !pan_mapped(mgmt_addr) |=>
		mgmt_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule

// file: design/pan_defs.svh
// Register map, field positions, reset values and timing figures
`ifndef PAN_DEFS_SVH
`define PAN_DEFS_SVH
`define PAN_ADDR_MODE_CTRL 5'h00
`define PAN_ADDR_MODE_STAT 5'h01
`define PAN_ADDR_ADVERT 5'h04
`define PAN_ADDR_PARTNER 5'h05
`define PAN_ADDR_EXPANSION 5'h06
`define PAN_ADDR_LINK_STAT 5'h10
`define PAN_CTL_SPEED 13
`define PAN_CTL_ANEN 12
`define PAN_CTL_RESTART 9
`define PAN_CTL_DUPLEX 8
`define PAN_CTL_RST_SPEED 1'h1
`define PAN_CTL_RST_ANEN 1'h1
`define PAN_CTL_RST_DUPLEX 1'h1
`define PAN_STAT_FIXED 16'h7849
`define PAN_STAT_CMPL 5
`define PAN_STAT_RFLT 4
`define PAN_STAT_LINK 2
`define PAN_ADV_HI 8
`define PAN_ADV_LO 5
`define PAN_ADV_ALL 4'hf
`define PAN_SEL_FIELD 16'h0001
`define PAN_NP_BIT 15
`define PAN_ACK_BIT 14
`define PAN_RF_BIT 13
`define PAN_PD_100 16'h0081
`define PAN_PD_10 16'h0021
`define PAN_EXP_PDF 4
`define PAN_EXP_LPNP 3
`define PAN_EXP_NP 2
`define PAN_EXP_PAGE 1
`define PAN_EXP_LPAN 0
`define PAN_LOCAL_NP 1'h0
`define PAN_LS_LINK 0
`define PAN_LS_SPEED10 1
`define PAN_LS_DUPLEX 2
`define PAN_LS_CMPL 4
`define PAN_STRAP_00 4'h3
`define PAN_STRAP_01 4'hc
`define PAN_STRAP_10 4'h5
`define PAN_STRAP_11 4'hf
`define PAN_CLK_KHZ 125000
`define PAN_BREAK_MS 1500
`define PAN_BURST_MS 16
`define PAN_TMR_W 28
`endif

// file: design/pan_pkg.sv
// Types shared by the negotiation modules
package pan_pkg;
	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_BREAK = 6'h02,
		ST_ABILITY = 6'h04,
		ST_ACK = 6'h08,
		ST_CHECK = 6'h10,
		ST_GOOD = 6'h20
	} pan_state_type;
endpackage

// file: design/pan_res_if.sv
// Abilities in, resolved common mode out
`timescale 1ns/100ps
interface pan_res_if;
	logic [3:0] local_adv;
	logic [3:0] partner_adv;
	logic valid;
	logic speed_100;
	logic full_duplex;
	modport resolver(input local_adv, input partner_adv, output valid, output speed_100,
		output full_duplex);
	modport user(output local_adv, output partner_adv, input valid, input speed_100,
		input full_duplex);
endinterface

// file: design/pan_strap_sample.sv
// Synchronises the two strap pins and captures them once after reset
`timescale 1ns/100ps
`include "pan_defs.svh"
module pan_strap_sample (
	input logic clock,
	input logic rstn,
	input logic adv_strap_hi,
	input logic adv_strap_lo,
	output logic [3:0] strap_adv,
	output logic strap_load
);
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic loaded;

	function automatic logic [3:0] pan_strap_map(input logic [1:0] code);
		unique case (code)
			2'h0: return `PAN_STRAP_00;
			2'h1: return `PAN_STRAP_01;
			2'h2: return `PAN_STRAP_10;
			2'h3: return `PAN_STRAP_11;
		endcase
	endfunction

	// Free running so the pins are settled when reset releases
	always_ff @(posedge clock) begin
		sync_a <= {adv_strap_hi, adv_strap_lo};
		sync_b <= sync_a;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			loaded <= 1'h0;
			strap_load <= 1'h0;
			strap_adv <= `PAN_ADV_ALL;
		end else begin
			loaded <= 1'h1;
			strap_load <= !loaded;
			if (!loaded)
				strap_adv <= pan_strap_map(sync_b);
		end
	end
endmodule

// file: design/pan_resolve.sv
// Picks the best mode common to both ends
`timescale 1ns/100ps
module pan_resolve (
	input logic clock,
	input logic rstn,
	pan_res_if.resolver res
);
	logic [3:0] common;

	// Result is {valid, speed_100, full_duplex}
	function automatic logic [2:0] pan_pick(input logic [3:0] c);
		if (c[3])
			return 3'h7;
		else if (c[2])
			return 3'h6;
		else if (c[1])
			return 3'h5;
		else if (c[0])
			return 3'h4;
		else
			return 3'h0;
	endfunction

	assign common = res.local_adv & res.partner_adv;
	assign {res.valid, res.speed_100, res.full_duplex} = pan_pick(common);

	pick_top_a: assert property (@(posedge clock) disable iff (!rstn)
		common[3] |-> res.valid && res.speed_100 && res.full_duplex)
		else $error("100 full duplex not chosen first");
	pick_order_a: assert property (@(posedge clock) disable iff (!rstn)
		(common[3:2] == 2'h0 && common[1]) |-> res.valid && !res.speed_100 && res.full_duplex)
		else $error("10 full duplex not chosen over 10 half");
endmodule

// file: verification/pan_partner_model.sv
// Remote link partner: answers bursts with its code word, raises link after ack
`timescale 1ns/100ps
module pan_partner_model (
	input logic clock,
	input logic rstn,
	input logic [2:0] mode,
	input logic [15:0] word,
	input logic flp_send,
	input logic [15:0] flp_word,
	input logic tx_hold,
	output logic rx_page_valid,
	output logic [15:0] rx_page_word,
	output logic link_100_good,
	output logic link_10_good
);
	logic [15:0] heard;
	logic [15:0] last;
	logic acked;
	logic fast;
	// Mode 0 silent, 1 negotiating, 2 forced 100, 3 forced 10, 4 both receivers see link
	assign fast = |(word[8:7] & heard[8:7]);
	assign rx_page_word = rx_page_valid ? last : ~last;
	assign link_100_good = (mode == 3'h1 && acked && fast) || mode == 3'h2 || mode == 3'h4;
	assign link_10_good = (mode == 3'h1 && acked && !fast) || mode == 3'h3 || mode == 3'h4;
	always @(posedge clock) begin
		rx_page_valid <= rstn && !tx_hold && mode == 3'h1 && flp_send;
		if (!rstn || tx_hold || mode != 3'h1) begin
			acked <= 1'b0;
			heard <= 16'h0000;
			if (!rstn) last <= 16'h0000;
		end else if (flp_send) begin
			heard <= flp_word;
			last <= word | {1'b0, flp_word[14], 14'h0000};
			if (flp_word[14]) acked <= 1'b1;
		end
	end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the negotiation block
`timescale 1ns/100ps
module testbench;
	localparam int unsigned BRK = 8;
	localparam int unsigned BST = 16;
	logic clock, rstn, adv_strap_hi, adv_strap_lo, mgmt_write, mgmt_read, rx_page_valid;
	logic link_100_good, link_10_good, flp_send, tx_hold, link_up, op_speed_100;
	logic op_full_duplex, neg_complete, rd_d, rf;
	logic [4:0] mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, rx_page_word, flp_word, pw, lfsr;
	logic [3:0] la, pa;
	logic [1:0] e;
	logic [2:0] pmode;
	logic [15:0] expq[$];
	int n_fail, cmp_count, n;

	pan_autoneg #(.BREAK_CYCLES(BRK), .BURST_CYCLES(BST)) i_dut (.clock(clock), .rstn(rstn),
		.adv_strap_hi(adv_strap_hi), .adv_strap_lo(adv_strap_lo), .mgmt_addr(mgmt_addr),
		.mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata(mgmt_rdata), .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word),
		.link_100_good(link_100_good), .link_10_good(link_10_good), .flp_send(flp_send),
		.flp_word(flp_word), .tx_hold(tx_hold), .link_up(link_up), .op_speed_100(op_speed_100),
		.op_full_duplex(op_full_duplex), .neg_complete(neg_complete));
	pan_partner_model i_partner (.clock(clock), .rstn(rstn), .mode(pmode), .word(pw),
		.flp_send(flp_send), .flp_word(flp_word), .tx_hold(tx_hold),
		.rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word),
		.link_100_good(link_100_good), .link_10_good(link_10_good));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [3:0] strap_map(input int k);
		case (k)
			0: return 4'h3;
			1: return 4'hc;
			2: return 4'h5;
			default: return 4'hf;
		endcase
	endfunction
	// Best common mode as {speed 100, full duplex}
	function automatic logic [1:0] best(input logic [3:0] c);
		if (c[3]) return 2'b11;
		if (c[2]) return 2'b10;
		if (c[1]) return 2'b01;
		return 2'b00;
	endfunction

	task automatic chk(input string name, input logic [15:0] ex, input logic [15:0] got);
		cmp_count++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, ex, got);
		end
	endtask
	task automatic chk_read(input logic [15:0] ex, input logic [15:0] got);
		chk("read", ex, got);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		mgmt_addr <= a;
		mgmt_wdata <= d;
		mgmt_write <= 1'b1;
		@(posedge clock);
		mgmt_write <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] ex);
		@(posedge clock);
		mgmt_addr <= a;
		mgmt_read <= 1'b1;
		expq.push_back(ex);
		@(posedge clock);
		mgmt_read <= 1'b0;
	endtask
	task automatic reset(input logic hi, input logic lo);
		@(posedge clock);
		rstn <= 1'b0;
		adv_strap_hi <= hi;
		adv_strap_lo <= lo;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
	endtask
	task automatic wait_cmpl;
		#1;
		for (n = 0; n < 300 && neg_complete !== 1'b1; n++) @(posedge clock) #1;
		chk("complete", 16'h0001, {15'h0000, neg_complete});
	endtask
	task automatic wait_burst(input int lim);
		#1;
		for (n = 0; n < lim && flp_send !== 1'b1; n++) @(posedge clock) #1;
		chk("burst", 16'h0001, {15'h0000, flp_send});
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Read results land one edge after the read is taken
	always @(posedge clock) begin
		if (rd_d) begin
			if (expq.size() == 0) chk("read order", 16'h0000, 16'hffff);
			else chk_read(expq.pop_front(), mgmt_rdata);
		end
		rd_d = mgmt_read;
	end

	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		test_done;
	end

	initial begin
		rstn = 1'b0;
		adv_strap_hi = 1'b0;
		adv_strap_lo = 1'b0;
		mgmt_addr = 5'h00;
		mgmt_write = 1'b0;
		mgmt_read = 1'b0;
		mgmt_wdata = 16'h0000;
		pmode = 3'h0;
		pw = 16'h0000;
		rd_d = 1'b0;
		lfsr = 16'h0053;
		n_fail = 0;
		cmp_count = 0;
		for (int k = 0; k < 4; k++) begin
			reset(k[1], k[0]);
			rd(5'h04, {7'h00, strap_map(k), 5'h01});
		end
		rd(5'h00, 16'h3100);
		rd(5'h01, 16'h7849);
		rd(5'h1f, 16'h0000);
		wr(5'h05, 16'hffff);
		rd(5'h05, 16'h0000);
		wait_burst(BST + 4);
		chk("burst word", 16'h01e1, flp_word);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			la = lfsr[3:0] | 4'h1;
			lfsr = lfsr_next(lfsr);
			pa = lfsr[3:0] | 4'h1;
			rf = lfsr[4];
			pw <= {2'b00, rf, 4'h0, pa, 5'h01};
			pmode <= 3'h1;
			wr(5'h04, {7'h00, la, 5'h01});
			wr(5'h00, 16'h1200);
			#1;
			for (n = 0; tx_hold === 1'b1 && n < 100; n++) @(posedge clock) #1;
			chk("break", 16'(BRK), 16'(n));
			wait_cmpl;
			e = best(la & pa);
			chk("mode", {14'h0, e}, {14'h0, op_speed_100, op_full_duplex});
			rd(5'h10, {11'h000, 1'b1, 1'b0, e[0], ~e[1], 1'b1});
			rd(5'h01, 16'h786d | {11'h000, rf, 4'h0});
			rd(5'h05, pw | 16'h4000);
			rd(5'h06, 16'h0003);
		end
		pmode <= 3'h0;
		repeat (3) @(posedge clock) #1;
		chk("link lost", 16'h0000, {15'h0000, link_up});
		wait_burst(BST + 4);
		pmode <= 3'h3;
		wr(5'h00, 16'h0100);
		repeat (2) @(posedge clock) #1;
		chk("forced", 16'h0005, {13'h0, link_up, op_speed_100, op_full_duplex});
		wr(5'h00, 16'h2000);
		repeat (2) @(posedge clock) #1;
		chk("forced", 16'h0002, {13'h0, link_up, op_speed_100, op_full_duplex});
		wr(5'h04, 16'h01e1);
		for (int k = 2; k < 4; k++) begin
			pmode <= 3'(k);
			wr(5'h00, 16'h0000);
			wr(5'h00, 16'h1000);
			wait_cmpl;
			rd(5'h05, (k == 2) ? 16'h0081 : 16'h0021);
			rd(5'h06, 16'h0000);
			chk("pd speed", {15'h0, k == 2}, {15'h0, op_speed_100});
		end
		pmode <= 3'h4;
		wr(5'h00, 16'h0000);
		wr(5'h00, 16'h1000);
		repeat (BRK + 4) @(posedge clock);
		rd(5'h06, 16'h0010);
		chk("no link", 16'h0000, {15'h0000, neg_complete});
		repeat (2) @(posedge clock);
		test_done;
	end
endmodule
